/* File: src/sync_event_distribution.v */
// sync event distribution: sources, selectors, timer, global reset and pll regs
//
// Notes on behaviour
// - sync pins active low, fire on release
// - software pulse register: one pulse per set bit
// - 32-bit count-down timer as sync source
// - timer bit 15 selects one-shot or periodic
// - timer reaching zero fires timer-selected blocks
// - none never fires; immediate fires on write
// - none only suppresses sync, block keeps running
// - thirteen blocks, one selector each
// - selector codes 0..5, 6 and 7 reserved
// - sync output pin driven by its source
// - global reset bits hold functions in reset
// - global reset comes up as 0x0033
// - reset and pll regs need no sample clock
// - pll multiplier fields, code 10 forbidden
// - pll test, bypass, power-down enable bits
// - timer zero sets status bit 4, maskable
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sync_dist_consts.vh"

module sync_event_distribution (
  // clock and reset
  input wire clk,
  input wire rst,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // hardware sync pins, active low
  input wire sync_a_n,
  input wire sync_b_n,
  output reg sync_out_n,
  // per-block parameter write strobes from the datapath
  input wire [12:0] param_written,
  // per-block sync pulses
  output reg [12:0] block_sync,
  // global reset outputs
  output reg config_reset,
  output reg datapath_reset,
  output reg core_pll_reset,
  output reg tx_pll_reset,
  // pll controls
  output reg [1:0] core_pll_mult,
  output reg core_pll_test,
  output reg core_pll_bypass,
  output reg core_pll_powerdown,
  output reg [1:0] tx_pll_mult,
  output reg tx_pll_test,
  output reg tx_pll_bypass,
  output reg tx_pll_powerdown,
  // timer event flag, gated by its mask
  output reg timer_event_flag
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  reg [15:0] global_reset_ctl_reg;
  reg [15:0] pll_config_reg;
  reg [12:0] software_pulse_reg;
  reg timer_periodic_reg;
  reg [31:0] timer_load_reg;
  reg [7:0] event_status_reg;
  reg [7:0] event_mask_reg;
  reg [38:0] selector_flat_reg;
  reg [7:0] dp_index_reg;
  reg dp_write_reg;
  reg [31:0] read_next;
  reg [15:0] pll_next;
  reg [12:0] sync_next;
  wire addr_phase;
  wire [7:0] addr_index;
  wire addr_aligned;
  wire pin_a_rise;
  wire pin_b_rise;
  wire [31:0] timer_count;
  wire timer_running;
  wire timer_zero;
  wire [3:0] sel_offset;

  assign addr_phase = hsel & hready & htrans[1];
  assign addr_index = haddr[9:2];
  assign addr_aligned = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h000000);
  assign sel_offset = dp_index_reg[3:0];

  // -----------------------------------------------------------------
  // sync sources
  // -----------------------------------------------------------------
  sync_pin_sampler pin_a_sampler (
    .clk(clk),
    .rst(rst),
    .pin_n(sync_a_n),
    .release_pulse(pin_a_rise)
  );

  sync_pin_sampler pin_b_sampler (
    .clk(clk),
    .rst(rst),
    .pin_n(sync_b_n),
    .release_pulse(pin_b_rise)
  );

  // the timer itself is started by its own selected sync source
  countdown_timer timer_unit (
    .clk(clk),
    .rst(rst),
    .start(block_sync[`BLK_TIMER]),
    .periodic(timer_periodic_reg),
    .load_value(timer_load_reg),
    .count(timer_count),
    .running(timer_running),
    .zero_pulse(timer_zero)
  );

  // -----------------------------------------------------------------
  // per-block source selection
  // -----------------------------------------------------------------
  genvar blk;
  generate
    for (blk = 0; blk < `NUM_BLOCKS; blk = blk + 1)
    begin : g_select
      wire [2:0] code;
      assign code = selector_flat_reg[blk*3 +: 3];
      always @*
      begin
        case (code)
          `SRC_NONE: sync_next[blk] = 1'b0;
          `SRC_SOFTWARE: sync_next[blk] = software_pulse_reg[blk];
          `SRC_TIMER: sync_next[blk] = timer_zero;
          `SRC_PIN_A: sync_next[blk] = pin_a_rise;
          `SRC_PIN_B: sync_next[blk] = pin_b_rise;
          `SRC_IMMEDIATE: sync_next[blk] = param_written[blk];
          default: sync_next[blk] = 1'b0;
        endcase
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // sync pulses and sync output pin
  // -----------------------------------------------------------------
  // a none selection gates only the pulse; block enables are elsewhere
  always @(posedge clk)
  begin
    if (rst)
    begin
      block_sync <= 13'h0000;
      sync_out_n <= 1'b1;
    end
    else
    begin
      block_sync <= sync_next;
      sync_out_n <= ~sync_next[`BLK_SYNC_OUT];
    end
  end

  // -----------------------------------------------------------------
  // pll write filter: forbidden multiplier code keeps the old field
  // -----------------------------------------------------------------
  always @*
  begin
    pll_next = hwdata[15:0] & `PLL_WRITABLE;
    if (pll_next[`PLL_CORE_MULT_LO +: 2] == `PLL_MULT_FORBIDDEN)
    begin
      pll_next[`PLL_CORE_MULT_LO +: 2] = pll_config_reg[`PLL_CORE_MULT_LO +: 2];
    end
    if (pll_next[`PLL_TX_MULT_LO +: 2] == `PLL_MULT_FORBIDDEN)
    begin
      pll_next[`PLL_TX_MULT_LO +: 2] = pll_config_reg[`PLL_TX_MULT_LO +: 2];
    end
  end

  // -----------------------------------------------------------------
  // read mux, evaluated in the address phase
  // -----------------------------------------------------------------
  always @*
  begin
    read_next = 32'h00000000;
    if (addr_aligned)
    begin
      if (addr_index == `IDX_GLOBAL_RESET_CTL)
      begin
        read_next = {16'h0000, global_reset_ctl_reg};
      end
      else if (addr_index == `IDX_PLL_CONFIG)
      begin
        read_next = {16'h0000, pll_config_reg};
      end
      else if (addr_index == `IDX_TIMER_SYNC)
      begin
        read_next = {16'h0000, timer_periodic_reg, 14'h0000, timer_running};
      end
      else if (addr_index == `IDX_TIMER_LOAD)
      begin
        read_next = timer_load_reg;
      end
      else if (addr_index == `IDX_TIMER_COUNT)
      begin
        read_next = timer_count;
      end
      else if (addr_index == `IDX_EVENT_STATUS)
      begin
        read_next = {24'h000000, event_status_reg};
      end
      else if (addr_index == `IDX_EVENT_MASK)
      begin
        read_next = {24'h000000, event_mask_reg};
      end
      else if (addr_index >= `IDX_SEL_BASE && addr_index <= `IDX_SEL_LAST)
      begin
        read_next = {29'h00000000, selector_flat_reg[addr_index[3:0]*3 +: 3]};
      end
    end
  end

  // -----------------------------------------------------------------
  // bus slave: zero wait states, always okay
  // -----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_index_reg <= 8'h00;
      dp_write_reg <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_phase)
      begin
        dp_write_reg <= hwrite & addr_aligned;
        dp_index_reg <= addr_index;
        hrdata <= hwrite ? 32'h00000000 : read_next;
      end
      else if (hready)
      begin
        dp_write_reg <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // register writes in the data phase
  // -----------------------------------------------------------------
  // these registers only need a bus edge, never a running sample path
  always @(posedge clk)
  begin
    if (rst)
    begin
      global_reset_ctl_reg <= `RST_GLOBAL_RESET_CTL;
      pll_config_reg <= `RST_PLL_CONFIG;
      software_pulse_reg <= 13'h0000;
      timer_periodic_reg <= 1'b0;
      timer_load_reg <= `RST_TIMER_LOAD;
      event_mask_reg <= 8'h00;
      selector_flat_reg <= 39'h0000000000;
    end
    else
    begin
      // pulses last one cycle only
      software_pulse_reg <= 13'h0000;
      if (dp_write_reg)
      begin
        case (dp_index_reg)
          `IDX_GLOBAL_RESET_CTL: global_reset_ctl_reg <= hwdata[15:0] & `GRST_WRITABLE;
          `IDX_PLL_CONFIG: pll_config_reg <= pll_next;
          `IDX_SOFTWARE_PULSE: software_pulse_reg <= hwdata[12:0];
          `IDX_TIMER_SYNC: timer_periodic_reg <= hwdata[`TIMER_PERIODIC_BIT];
          `IDX_TIMER_LOAD: timer_load_reg <= hwdata;
          `IDX_EVENT_MASK: event_mask_reg <= hwdata[7:0];
          default:
          begin
            if (dp_index_reg >= `IDX_SEL_BASE && dp_index_reg <= `IDX_SEL_LAST)
            begin
              selector_flat_reg[sel_offset*3 +: 3] <= hwdata[2:0];
            end
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // event status: write one to clear, a new event wins over the clear
  // -----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      event_status_reg <= 8'h00;
    end
    else
    begin
      if (dp_write_reg && dp_index_reg == `IDX_EVENT_STATUS)
      begin
        event_status_reg <= event_status_reg & ~hwdata[7:0];
      end
      if (timer_zero)
      begin
        event_status_reg[`STATUS_TIMER_ZERO_BIT] <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // registered control outputs
  // -----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      config_reset <= 1'b1;
      datapath_reset <= 1'b1;
      core_pll_reset <= 1'b1;
      tx_pll_reset <= 1'b1;
      core_pll_mult <= 2'b00;
      core_pll_test <= 1'b0;
      core_pll_bypass <= 1'b0;
      core_pll_powerdown <= 1'b0;
      tx_pll_mult <= 2'b00;
      tx_pll_test <= 1'b0;
      tx_pll_bypass <= 1'b0;
      tx_pll_powerdown <= 1'b0;
      timer_event_flag <= 1'b0;
    end
    else
    begin
      config_reset <= global_reset_ctl_reg[0];
      datapath_reset <= global_reset_ctl_reg[1];
      core_pll_reset <= global_reset_ctl_reg[4];
      tx_pll_reset <= global_reset_ctl_reg[5];
      core_pll_mult <= pll_config_reg[`PLL_CORE_MULT_LO +: 2];
      core_pll_test <= pll_config_reg[`PLL_CORE_TEST];
      core_pll_bypass <= pll_config_reg[`PLL_CORE_BYPASS];
      core_pll_powerdown <= pll_config_reg[`PLL_CORE_PDN];
      tx_pll_mult <= pll_config_reg[`PLL_TX_MULT_LO +: 2];
      tx_pll_test <= pll_config_reg[`PLL_TX_TEST];
      tx_pll_bypass <= pll_config_reg[`PLL_TX_BYPASS];
      tx_pll_powerdown <= pll_config_reg[`PLL_TX_PDN];
      timer_event_flag <= event_status_reg[`STATUS_TIMER_ZERO_BIT]
        & event_mask_reg[`STATUS_TIMER_ZERO_BIT];
    end
  end

  // hsize is accepted but only whole-word transfers are supported
  wire unused_hsize;
  assign unused_hsize = ^hsize;

endmodule // sync_event_distribution

`default_nettype wire

/* File: shared/sync_dist_consts.vh */
// constants for the sync event distribution block
`ifndef SYNC_DIST_CONSTS_VH
`define SYNC_DIST_CONSTS_VH

// register indexes; byte address is four times the index
`define IDX_GLOBAL_RESET_CTL 8'h00
`define IDX_PLL_CONFIG 8'h01
`define IDX_SOFTWARE_PULSE 8'h10
`define IDX_TIMER_SYNC 8'h11
`define IDX_TIMER_LOAD 8'h12
`define IDX_TIMER_COUNT 8'h13
`define IDX_EVENT_STATUS 8'h14
`define IDX_EVENT_MASK 8'h15
`define IDX_SEL_BASE 8'h20
`define IDX_SEL_LAST 8'h2c

// reset values
`define RST_GLOBAL_RESET_CTL 16'h0033
`define RST_PLL_CONFIG 16'h0000
`define RST_TIMER_LOAD 32'hffffffff

// field positions and masks
`define GRST_WRITABLE 16'h0033
`define PLL_WRITABLE 16'h1f1f
`define PLL_CORE_MULT_LO 0
`define PLL_CORE_TEST 2
`define PLL_CORE_BYPASS 3
`define PLL_CORE_PDN 4
`define PLL_TX_MULT_LO 8
`define PLL_TX_TEST 10
`define PLL_TX_BYPASS 11
`define PLL_TX_PDN 12
`define PLL_MULT_FORBIDDEN 2'b10
`define TIMER_PERIODIC_BIT 15
`define STATUS_TIMER_ZERO_BIT 4

// block count and source codes
`define NUM_BLOCKS 13
`define BLK_TIMER 3
`define BLK_SYNC_OUT 9
`define SRC_NONE 3'h0
`define SRC_SOFTWARE 3'h1
`define SRC_TIMER 3'h2
`define SRC_PIN_A 3'h3
`define SRC_PIN_B 3'h4
`define SRC_IMMEDIATE 3'h5

`endif

/* File: src/sync_pin_sampler.v */
// sampler and release-edge detector for one active-low sync pin
`timescale 1ns/1ps
`default_nettype none

module sync_pin_sampler (
  // clock and reset
  input wire clk,
  input wire rst,
  // pin and event
  input wire pin_n,
  output reg release_pulse
);

  reg stage1_reg;
  reg stage2_reg;
  reg stage3_reg;
  reg level_reg;

  // -----------------------------------------------------------------
  // three-flop capture, low taken from stage three alone, high accepted once stages two and three agree
  // -----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      stage1_reg <= 1'b1;
      stage2_reg <= 1'b1;
      stage3_reg <= 1'b1;
      level_reg <= 1'b1;
      release_pulse <= 1'b0;
    end
    else
    begin
      stage1_reg <= pin_n;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      release_pulse <= 1'b0;
      // a legal sync pulse is low for one cycle only, so a single low sample arms;
      // the release still needs stages two and three to agree on high
      if (!stage3_reg)
      begin
        level_reg <= 1'b0;
      end
      else if (stage2_reg)
      begin
        level_reg <= 1'b1;
        // fire on release: low to high
        release_pulse <= ~level_reg;
      end
    end
  end

endmodule // sync_pin_sampler

`default_nettype wire

/* File: src/countdown_timer.v */
// 32-bit count-down timer with one-shot and periodic modes
`timescale 1ns/1ps
`default_nettype none

module countdown_timer (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire start,
  input wire periodic,
  input wire [31:0] load_value,
  // status
  output reg [31:0] count,
  output reg running,
  output reg zero_pulse
);

  // -----------------------------------------------------------------
  // counting
  // -----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      count <= 32'h00000000;
      running <= 1'b0;
      zero_pulse <= 1'b0;
    end
    else
    begin
      zero_pulse <= 1'b0;
      if (start)
      begin
        count <= load_value;
        running <= 1'b1;
      end
      else if (running)
      begin
        if (count == 32'h00000001 || count == 32'h00000000)
        begin
          zero_pulse <= 1'b1;
          // periodic reload keeps the period at load_value cycles
          count <= periodic ? load_value : 32'h00000000;
          running <= periodic;
        end
        else
        begin
          count <= count - 32'h00000001;
        end
      end
    end
  end

endmodule // countdown_timer

`default_nettype wire

/* File: bench/sync_event_distribution_sva.sv */
// assertion checker for the sync event distribution block
`timescale 1ns/1ps
`default_nettype none
`include "sync_dist_consts.vh"

module sync_event_distribution_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  // sync
  input wire logic sync_a_n,
  input wire logic [12:0] param_written,
  input wire logic [12:0] block_sync,
  // reset and pll outputs
  input wire logic config_reset,
  input wire logic datapath_reset,
  input wire logic core_pll_reset,
  input wire logic tx_pll_reset,
  input wire logic [1:0] core_pll_mult,
  input wire logic core_pll_test,
  input wire logic core_pll_bypass,
  input wire logic core_pll_powerdown
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // --------------------------------------------------------------
  // shadow of the write data phase and of the selectors
  // --------------------------------------------------------------
  logic dp;
  logic [7:0] ai;
  logic [2:0] sel [13];
  logic [12:0] dead, imm, swm, pam;
  always_ff @(posedge clk)
  begin
    dp <= !rst && hsel && hready && htrans[1] && hwrite && haddr[31:10] == 0 && haddr[1:0] == 0;
    ai <= haddr[9:2];
  end
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 13; i++)
      if (rst)
        sel[i] <= 3'h0;
      else if (dp && ai == `IDX_SEL_BASE + i)
        sel[i] <= hwdata[2:0];
  end
  always_comb
  begin
    for (int i = 0; i < 13; i++)
    begin
      dead[i] = sel[i] == `SRC_NONE || sel[i] > `SRC_IMMEDIATE;
      imm[i] = sel[i] == `SRC_IMMEDIATE;
      swm[i] = sel[i] == `SRC_SOFTWARE;
      pam[i] = sel[i] == `SRC_PIN_A;
    end
  end
  sequence wr_to(logic [7:0] idx);
    dp && ai == idx;
  endsequence
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  reset_values_a: assert property ($fell(rst) |->
    config_reset && datapath_reset && core_pll_reset && tx_pll_reset && block_sync == 0)
    else $error("reset outputs wrong after reset");
  reset_follow_a: assert property (wr_to(`IDX_GLOBAL_RESET_CTL) |-> ##2
    {tx_pll_reset, core_pll_reset, datapath_reset, config_reset} ==
    {$past(hwdata[5:4], 2), $past(hwdata[1:0], 2)})
    else $error("reset outputs do not follow the write");
  pll_bits_a: assert property (wr_to(`IDX_PLL_CONFIG) |-> ##2
    {core_pll_powerdown, core_pll_bypass, core_pll_test} == $past(hwdata[4:2], 2))
    else $error("pll enable bits do not follow the write");
  mult_keep_a: assert property (wr_to(`IDX_PLL_CONFIG) ##0 hwdata[1:0] != 2'b10 |-> ##2
    core_pll_mult == $past(hwdata[1:0], 2))
    else $error("pll multiplier does not follow the write");
  mult_legal_a: assert property (core_pll_mult != `PLL_MULT_FORBIDDEN)
    else $error("forbidden pll multiplier reached the output");
  never_fire_a: assert property ((block_sync & dead) == 0)
    else $error("block with no source fired");
  immediate_next_a: assert property ((param_written & imm) != 0 |=>
    (block_sync & $past(param_written & imm)) == $past(param_written & imm))
    else $error("immediate block missed its update");
  soft_pulse_a: assert property (wr_to(`IDX_SOFTWARE_PULSE) |-> ##2
    (block_sync & swm) == ($past(hwdata[12:0], 2) & swm))
    else $error("software pulses wrong");
  pin_release_a: assert property ($rose(sync_a_n) && pam != 0 |->
    ##[1:8] (block_sync & pam) == pam)
    else $error("pin release not delivered");
endmodule // sync_event_distribution_sva

bind sync_event_distribution sync_event_distribution_sva i_sync_event_distribution_sva (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hwdata(hwdata), .sync_a_n(sync_a_n), .param_written(param_written),
  .block_sync(block_sync), .config_reset(config_reset), .datapath_reset(datapath_reset),
  .core_pll_reset(core_pll_reset), .tx_pll_reset(tx_pll_reset), .core_pll_mult(core_pll_mult),
  .core_pll_test(core_pll_test), .core_pll_bypass(core_pll_bypass),
  .core_pll_powerdown(core_pll_powerdown)
);
`default_nettype wire

/* File: bench/sync_pin_driver.sv */
// model of the outside logic that pulses the two sync pins
`timescale 1ns/1ps
`default_nettype none

module sync_pin_driver (
  // clock
  input wire logic clk,
  // requests, bit 0 pin a, bit 1 pin b
  input wire logic [1:0] fire,
  // pins, active low, idle high
  output logic sync_a_n,
  output logic sync_b_n
);
  initial {sync_b_n, sync_a_n} = 2'b11;
  // a request lasts one cycle, so the pin is low for exactly one cycle
  always @(posedge clk)
  begin
    {sync_b_n, sync_a_n} <= ~fire;
  end
endmodule // sync_pin_driver
`default_nettype wire

/* File: bench/sync_event_distribution_test.sv */
// self-checking testbench for the sync event distribution block
`timescale 1ns/1ps
`default_nettype none
`include "sync_dist_consts.vh"

module sync_event_distribution_test;
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, sync_a_n, sync_b_n, sync_out_n;
  logic config_reset, datapath_reset, core_pll_reset, tx_pll_reset, timer_event_flag;
  logic core_pll_test, core_pll_bypass, core_pll_powerdown, tx_pll_test, tx_pll_bypass;
  logic tx_pll_powerdown;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, fire, core_pll_mult, tx_pll_mult;
  logic [2:0] hsize;
  logic [12:0] param_written, block_sync, got;
  int fails, comparisons, lows, v, w, pll_m, cnt[13], snap[13], sel_m[13];

  assign hready = hreadyout;
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // pulse counters per block and low cycles of the sync output pin
  always @(posedge clk)
  begin
    for (int i = 0; i < 13; i++)
      cnt[i] += block_sync[i];
    lows += (sync_out_n === 1'b0);
  end

  sync_event_distribution i_sync_event_distribution (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sync_a_n(sync_a_n), .sync_b_n(sync_b_n), .sync_out_n(sync_out_n),
    .param_written(param_written), .block_sync(block_sync), .config_reset(config_reset),
    .datapath_reset(datapath_reset), .core_pll_reset(core_pll_reset),
    .tx_pll_reset(tx_pll_reset), .core_pll_mult(core_pll_mult), .core_pll_test(core_pll_test),
    .core_pll_bypass(core_pll_bypass), .core_pll_powerdown(core_pll_powerdown),
    .tx_pll_mult(tx_pll_mult), .tx_pll_test(tx_pll_test), .tx_pll_bypass(tx_pll_bypass),
    .tx_pll_powerdown(tx_pll_powerdown), .timer_event_flag(timer_event_flag)
  );
  sync_pin_driver i_sync_pin_driver (
    .clk(clk), .fire(fire), .sync_a_n(sync_a_n), .sync_b_n(sync_b_n)
  );

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // single ahb-lite transfer; never assumes a wait count
  task automatic bus(input logic wr, input int idx, input logic [31:0] d);
    @(posedge clk);
    hwrite <= wr;
    haddr <= 32'(idx) << 2;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  function automatic logic [12:0] sel_is(input int code);
    for (int i = 0; i < 13; i++)
      sel_is[i] = sel_m[i] == code;
  endfunction
  // every expected block fires exactly once, no other block fires exactly once
  task automatic window(input int n, input logic [12:0] e, input string what);
    int low0;
    snap = cnt;
    low0 = lows;
    repeat (n) @(posedge clk);
    for (int i = 0; i < 13; i++)
      got[i] = (cnt[i] - snap[i]) == 1;
    check(what, got, e);
    check("sync out low cycles", lows - low0, e[9]);
  endtask
  task automatic conclude();
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    fails++;
    conclude();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    {hsel, hwrite, htrans, fire, haddr, hwdata, param_written} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    v = $urandom(32'h95dcc3b6);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    hsel <= 1'b1;
    bus(0, `IDX_GLOBAL_RESET_CTL, 0);
    check("reset ctl", q, `RST_GLOBAL_RESET_CTL);
    bus(0, `IDX_PLL_CONFIG, 0);
    check("pll config", q, `RST_PLL_CONFIG);
    bus(0, `IDX_TIMER_LOAD, 0);
    check("timer load", q, `RST_TIMER_LOAD);
    bus(1, 8'hff, 32'hffffffff);
    bus(0, 8'hff, 0);
    check("unmapped", q, 0);
    // first pass writes the forbidden multiplier code in both fields
    for (int k = 0; k < 8; k++)
    begin
      v = (k == 0) ? 32'h1e1e : $urandom;
      w = v & `PLL_WRITABLE;
      if (w[1:0] == 2'b10)
        w[1:0] = pll_m[1:0];
      if (w[9:8] == 2'b10)
        w[9:8] = pll_m[9:8];
      pll_m = w;
      bus(1, `IDX_GLOBAL_RESET_CTL, v);
      bus(1, `IDX_PLL_CONFIG, v);
      repeat (2) @(posedge clk);
      check("reset outputs", {tx_pll_reset, core_pll_reset, datapath_reset, config_reset},
        {v[5:4], v[1:0]});
      check("pll outputs", {tx_pll_powerdown, tx_pll_bypass, tx_pll_test, tx_pll_mult,
        core_pll_powerdown, core_pll_bypass, core_pll_test, core_pll_mult},
        {pll_m[12:8], pll_m[4:0]});
      bus(0, `IDX_GLOBAL_RESET_CTL, 0);
      check("reset ctl", q, v & `GRST_WRITABLE);
      bus(0, `IDX_PLL_CONFIG, 0);
      check("pll config", q, pll_m);
    end
    bus(1, `IDX_GLOBAL_RESET_CTL, 0);
    repeat (3)
    begin
      for (int i = 0; i < 13; i++)
      begin
        sel_m[i] = $urandom % 8;
        if (i inside {0, 1, 2, 7})
          sel_m[i] = 3 + $urandom % 2;
        if (i inside {5, 11, 12})
          sel_m[i] = $urandom % 5;
        bus(1, `IDX_SEL_BASE + i, sel_m[i]);
      end
      v = $urandom;
      bus(1, `IDX_SOFTWARE_PULSE, v);
      window(12, v[12:0] & sel_is(`SRC_SOFTWARE), "software pulses");
      @(posedge clk);
      param_written <= v[25:13];
      @(posedge clk);
      param_written <= 0;
      window(6, v[25:13] & sel_is(`SRC_IMMEDIATE), "immediate");
      for (int k = 0; k < 2; k++)
      begin
        @(posedge clk);
        fire <= 2'(1 << k);
        @(posedge clk);
        fire <= 2'b00;
        window(16, sel_is(`SRC_PIN_A + k), "pin release");
      end
    end
    // block 3 starts the timer, block 4 follows the timer
    sel_m[3] = `SRC_SOFTWARE;
    bus(1, `IDX_SEL_BASE + 3, sel_m[3]);
    sel_m[4] = `SRC_TIMER;
    bus(1, `IDX_SEL_BASE + 4, sel_m[4]);
    w = 20;
    bus(1, `IDX_TIMER_LOAD, w);
    bus(1, `IDX_EVENT_MASK, 32'h10);
    for (int k = 0; k < 2; k++)
    begin
      bus(1, `IDX_TIMER_SYNC, k << `TIMER_PERIODIC_BIT);
      bus(0, `IDX_TIMER_SYNC, 0);
      check("timer mode", q[15], k);
      bus(1, `IDX_SOFTWARE_PULSE, 32'h8);
      snap = cnt;
      repeat (70) @(posedge clk);
      check("timer events", cnt[4] - snap[4], k ? (70 - 5) / w : 1);
      if (k == 0)
      begin
        bus(0, `IDX_EVENT_STATUS, 0);
        check("timer status", q[4], 1);
        bus(0, `IDX_TIMER_COUNT, 0);
        check("one-shot count", q, 0);
        check("timer flag", timer_event_flag, 1);
        bus(1, `IDX_EVENT_STATUS, 32'h10);
        repeat (2) @(posedge clk);
        check("timer flag clear", timer_event_flag, 0);
      end
    end
    conclude();
  end
endmodule // sync_event_distribution_test
`default_nettype wire
